// *** core/term_pkg.sv ***
// shared constants for the on-die termination control block
package term_pkg;

  // widths and structure
  localparam int CFG_W     = 8;
  localparam int FIELD_W   = 3;
  localparam int CNT_W     = 6;
  localparam int BAND_W    = 3;
  localparam int NUM_BANDS = 8;
  localparam int NUM_SLOTS = 8;

  // termination_config_reg field layout
  localparam int DATA_FIELD_LSB = 0;
  localparam int DATA_FIELD_MSB = 2;
  localparam int CA_FIELD_LSB   = 4;
  localparam int CA_FIELD_MSB   = 6;

  // reset values and codes
  localparam logic [FIELD_W-1:0] FIELD_OFF   = 3'h0;
  localparam logic [FIELD_W-1:0] CA_CODE_MAX = 3'h6;

  // ca_term_update_time, rounded up to whole CLK cycles
  localparam int CA_UPDATE_TIME_PS = 20000;
  localparam int CLK_PERIOD_PS     = 25000;
  localparam int CA_UPDATE_CYC     = (CA_UPDATE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] CA_UPDATE_CNT =
    CNT_W'((CA_UPDATE_CYC < 1) ? 1 : CA_UPDATE_CYC);

  // counter helpers
  localparam logic [CNT_W-1:0] CNT_ZERO   = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;
  localparam logic [CNT_W-1:0] BL32_EXTRA = 6'h08;

  // latencies in link clock cycles, indexed by frequency band
  // band 0: >10..266, 1: ..533, 2: ..800, 3: ..1066, 4: ..1333, 5: ..1600, 6: ..1866, 7: ..2133
  typedef logic [CNT_W-1:0] lat_tab_t [NUM_BANDS];
  localparam lat_tab_t ON_LAT_A  = '{6'h02, 6'h02, 6'h02, 6'h04, 6'h04, 6'h06, 6'h06, 6'h08};
  localparam lat_tab_t ON_LAT_B  = '{6'h02, 6'h02, 6'h06, 6'h0C, 6'h0E, 6'h12, 6'h14, 6'h18};
  localparam lat_tab_t OFF_LAT_A = '{6'h0E, 6'h10, 6'h12, 6'h14, 6'h16, 6'h18, 6'h1A, 6'h1C};
  localparam lat_tab_t OFF_LAT_B = '{6'h0E, 6'h12, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28, 6'h2C};

endpackage : term_pkg

// *** core/term_word_sync.sv ***
// toggle handshake carrying one termination field word between clock domains
`timescale 1ns/10ps
`default_nettype none
module term_word_sync
(
  // source side
  input  wire logic                        src_clk,
  input  wire logic                        src_rst_n,
  input  wire logic                        src_load,
  input  wire logic [term_pkg::FIELD_W-1:0] src_word,
  // destination side
  input  wire logic                        dst_clk,
  input  wire logic                        dst_rst_n,
  output logic                             dst_valid,
  output logic [term_pkg::FIELD_W-1:0]     dst_word
);
  import term_pkg::*;

  typedef struct packed {
    logic               req;
    logic               pend;
    logic [FIELD_W-1:0] pend_word;
    logic [FIELD_W-1:0] hold;
    logic               ack_s1;
    logic               ack_s2;
  } src_state_t;

  typedef struct packed {
    logic               req_s1;
    logic               req_s2;
    logic               req_s3;
    logic               ack;
    logic               valid;
    logic [FIELD_W-1:0] word;
  } dst_state_t;

  src_state_t src_r;
  src_state_t src_nxt;
  dst_state_t dst_r;
  dst_state_t dst_nxt;

  // source: hold stays put until the far side echoes the toggle
  always_comb
  begin
    src_nxt        = src_r;
    src_nxt.ack_s1 = dst_r.ack;
    src_nxt.ack_s2 = src_r.ack_s1;
    if ((src_r.req == src_r.ack_s2) && src_r.pend)
    begin
      src_nxt.hold = src_r.pend_word;
      src_nxt.req  = ~src_r.req;
      src_nxt.pend = 1'b0;
    end
    // a new word landing during a send is kept, latest one wins
    if (src_load)
    begin
      src_nxt.pend      = 1'b1;
      src_nxt.pend_word = src_word;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n)
  begin
    if (!src_rst_n)
      src_r <= '0;
    else
      src_r <= src_nxt;
  end

  // destination: edge of the synchronised toggle marks a stable hold
  always_comb
  begin
    dst_nxt        = dst_r;
    dst_nxt.req_s1 = src_r.req;
    dst_nxt.req_s2 = dst_r.req_s1;
    dst_nxt.req_s3 = dst_r.req_s2;
    dst_nxt.ack    = dst_r.req_s3;
    dst_nxt.valid  = dst_r.req_s2 != dst_r.req_s3;
    if (dst_r.req_s2 != dst_r.req_s3)
      dst_nxt.word = src_r.hold;
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n)
  begin
    if (!dst_rst_n)
      dst_r <= '0;
    else
      dst_r <= dst_nxt;
  end

  assign dst_valid = dst_r.valid;
  assign dst_word  = dst_r.word;

endmodule : term_word_sync
`default_nettype wire

// *** core/dram_on_die_termination_ctrl.sv ***
// termination control: data-side windows on the link clock, command-side value on CLK
//
// Summary of operation
// - new command termination applied after update time
// - data, mask and strobe termination switched internally
// - data termination off in power-down, self-refresh
// - nonzero data field enables, selects value
// - termination idle until write command sampled
// - termination returns off after burst ends
// - turn-on latency counted from second column command
// - turn-off latency counted from second column command
// - latencies chosen by frequency band and set
// - burst length 32 adds eight cycles off
// - write leveling: strobe terminated, data off
// - command field codes one to six valid
// - command termination disabled at reset, kept in power-down
// - bond pad low never terminates command bus
`timescale 1ns/10ps
`default_nettype none
module dram_on_die_termination_ctrl
(
  // system clock and reset
  input  wire logic                            CLK,
  input  wire logic                            RESETN,
  // link clock from the memory controller
  input  wire logic                            LINK_CK,
  // commands, sampled on LINK_CK
  input  wire logic                            CMD_WRITE1,
  input  wire logic                            CMD_CAS2,
  input  wire logic                            CMD_MRW_TERM,
  input  wire logic [term_pkg::CFG_W-1:0]      MRW_DATA,
  // device state and latency selection, LINK_CK domain
  input  wire logic                            POWER_DOWN,
  input  wire logic                            SELF_REFRESH,
  input  wire logic                            WRITE_LEVEL,
  input  wire logic [term_pkg::BAND_W-1:0]     FREQ_BAND,
  input  wire logic                            WRITE_LATENCY_SET_B,
  input  wire logic                            BURST_LEN_32,
  // data-side termination controls, LINK_CK domain
  output logic                                 DQ_TERM_EN,
  output logic                                 DQS_TERM_EN,
  output logic                                 DATA_MASK_INV_TERM_EN,
  output logic [term_pkg::FIELD_W-1:0]         DATA_TERM_VALUE,
  output logic                                 WRITE_SLOT_OVERFLOW,
  // command-side termination, CLK domain
  input  wire logic                            CA_TERM_BOND_PAD,
  output logic                                 CA_TERM_EN,
  output logic [term_pkg::FIELD_W-1:0]         CA_TERM_VALUE,
  output logic                                 CA_UPDATE_BUSY
);
  import term_pkg::*;

  // one outstanding write: turn-on and turn-off countdowns
  typedef struct packed {
    logic             act;
    logic [CNT_W-1:0] on_cnt;
    logic [CNT_W-1:0] off_cnt;
  } slot_t;

  typedef struct packed {
    logic [FIELD_W-1:0]          dfield;
    logic                        wr_pend;
    slot_t [NUM_SLOTS-1:0]       slot;
    logic                        dq_en;
    logic                        dqs_en;
    logic                        dmi_en;
    logic [FIELD_W-1:0]          dval;
    logic                        ovf;
  } link_state_t;

  typedef struct packed {
    logic               pad_s1;
    logic               pad_s2;
    logic [FIELD_W-1:0] staged;
    logic [FIELD_W-1:0] cafield;
    logic               busy;
    logic [CNT_W-1:0]   cnt;
    logic               ca_en;
    logic [FIELD_W-1:0] ca_val;
  } sys_state_t;

  link_state_t           lr;
  link_state_t           ln;
  sys_state_t            sr;
  sys_state_t            sn;
  logic [1:0]            lrst_q;
  logic                  link_rst_n;
  logic [NUM_SLOTS-1:0]  win_r;
  logic [NUM_SLOTS-1:0]  slot_busy;
  logic                  term_gate;
  logic [CNT_W-1:0]      on_sel;
  logic [CNT_W-1:0]      off_sel;
  logic                  cfg_valid;
  logic [FIELD_W-1:0]    cfg_word;
  logic                  ca_ok;

  // link reset: asserts at once, releases on the link clock
  always_ff @(posedge LINK_CK or negedge RESETN)
  begin
    if (!RESETN)
      lrst_q <= 2'h0;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end

  assign link_rst_n = lrst_q[1];

  // command field leaves the link domain through a handshake
  term_word_sync u_ca_sync
  (
    .src_clk   (LINK_CK),
    .src_rst_n (link_rst_n),
    .src_load  (CMD_MRW_TERM),
    .src_word  (MRW_DATA[CA_FIELD_MSB:CA_FIELD_LSB]),
    .dst_clk   (CLK),
    .dst_rst_n (RESETN),
    .dst_valid (cfg_valid),
    .dst_word  (cfg_word)
  );

  // termination window of each slot, from registered counts
  for (genvar g = 0; g < NUM_SLOTS; g++)
  begin : g_win
    assign win_r[g] = lr.slot[g].act && (lr.slot[g].on_cnt == CNT_ZERO) &&
                      (lr.slot[g].off_cnt != CNT_ZERO);
    assign slot_busy[g] = lr.slot[g].act;
  end

  // latency lookup for the band in use
  always_comb
  begin
    if (WRITE_LATENCY_SET_B)
    begin
      on_sel  = ON_LAT_B[FREQ_BAND];
      off_sel = OFF_LAT_B[FREQ_BAND];
    end
    else
    begin
      on_sel  = ON_LAT_A[FREQ_BAND];
      off_sel = OFF_LAT_A[FREQ_BAND];
    end
    if (BURST_LEN_32)
      off_sel = off_sel + BL32_EXTRA;
  end

  // data termination is only ever allowed while powered and enabled
  assign term_gate = (lr.dfield != FIELD_OFF) && !POWER_DOWN && !SELF_REFRESH;

  // link domain next state
  always_comb
  begin
    logic found;
    found = 1'b0;
    ln    = lr;
    ln.ovf = 1'b0;
    // data field takes effect the cycle after the mode write
    if (CMD_MRW_TERM)
      ln.dfield = MRW_DATA[DATA_FIELD_MSB:DATA_FIELD_LSB];
    // countdowns; a slot frees once its turn-off point passes
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (lr.slot[i].act)
      begin
        if (lr.slot[i].on_cnt != CNT_ZERO)
          ln.slot[i].on_cnt = lr.slot[i].on_cnt - CNT_ONE;
        if (lr.slot[i].off_cnt != CNT_ZERO)
          ln.slot[i].off_cnt = lr.slot[i].off_cnt - CNT_ONE;
        else
          ln.slot[i].act = 1'b0;
      end
    end
    // second column command of a write starts a fresh slot;
    // counts load one short because the output stage adds a cycle
    if (CMD_CAS2 && lr.wr_pend && (lr.dfield != FIELD_OFF))
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        if (!found && !lr.slot[i].act)
        begin
          ln.slot[i].act     = 1'b1;
          ln.slot[i].on_cnt  = on_sel - CNT_ONE;
          ln.slot[i].off_cnt = off_sel - CNT_ONE;
          found              = 1'b1;
        end
      end
      // more writes in flight than slots: that write gets no window
      ln.ovf = !found;
    end
    // first part of a write arms; set wins over the clear
    if (CMD_CAS2)
      ln.wr_pend = 1'b0;
    if (CMD_WRITE1)
      ln.wr_pend = 1'b1;
    // outputs: high impedance unless a window or leveling asks
    ln.dq_en  = term_gate && !WRITE_LEVEL && (|win_r);
    ln.dmi_en = term_gate && !WRITE_LEVEL && (|win_r);
    ln.dqs_en = term_gate && (WRITE_LEVEL || (|win_r));
    ln.dval   = term_gate ? lr.dfield : FIELD_OFF;
  end

  always_ff @(posedge LINK_CK or negedge link_rst_n)
  begin
    if (!link_rst_n)
      lr <= '0;
    else
      lr <= ln;
  end

  assign DQ_TERM_EN            = lr.dq_en;
  assign DQS_TERM_EN           = lr.dqs_en;
  assign DATA_MASK_INV_TERM_EN = lr.dmi_en;
  assign DATA_TERM_VALUE       = lr.dval;
  assign WRITE_SLOT_OVERFLOW   = lr.ovf;

  // code 7 is outside the defined set and terminates nothing
  assign ca_ok = (sr.cafield != FIELD_OFF) && (sr.cafield <= CA_CODE_MAX);

  // system domain next state
  always_comb
  begin
    sn        = sr;
    sn.pad_s1 = CA_TERM_BOND_PAD;
    sn.pad_s2 = sr.pad_s1;
    // hold the old value until the update time has run out
    if (sr.busy)
    begin
      if (sr.cnt == CNT_ONE)
      begin
        sn.cafield = sr.staged;
        sn.busy    = 1'b0;
      end
      else
        sn.cnt = sr.cnt - CNT_ONE;
    end
    // a later write restarts the wait with the newer value
    if (cfg_valid)
    begin
      sn.staged = cfg_word;
      sn.busy   = 1'b1;
      sn.cnt    = CA_UPDATE_CNT;
    end
    // power state does not enter here, so command termination stays on
    sn.ca_en  = sr.pad_s2 && ca_ok;
    sn.ca_val = (sr.pad_s2 && ca_ok) ? sr.cafield : FIELD_OFF;
  end

  // reset leaves the command field at zero: termination disabled
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      sr <= '0;
    else
      sr <= sn;
  end

  assign CA_TERM_EN     = sr.ca_en;
  assign CA_TERM_VALUE  = sr.ca_val;
  assign CA_UPDATE_BUSY = sr.busy;

  // arrival leaves the field alone for the wait, then applies it
  AST_CA_UPDATE_WAIT: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_valid |=> $stable(sr.cafield) ##1 (sr.cafield == $past(cfg_word, 2)))
    else $error("command termination value not applied after update time");

  AST_PAD_LOW_NO_CA: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !sr.pad_s2 |=> !CA_TERM_EN && (CA_TERM_VALUE == FIELD_OFF))
    else $error("command bus terminated with bond pad low");

  AST_CA_CODE_DECODE: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (sr.pad_s2 && ca_ok) |=> CA_TERM_EN && (CA_TERM_VALUE == $past(sr.cafield)))
    else $error("valid command code not applied");

  AST_DATA_OFF_LOW_POWER: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (POWER_DOWN || SELF_REFRESH) |=> !DQ_TERM_EN && !DQS_TERM_EN && !DATA_MASK_INV_TERM_EN)
    else $error("data termination on during power-down or self-refresh");

  AST_DATA_FIELD_ZERO: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (lr.dfield == FIELD_OFF) |=> !DQ_TERM_EN && !DQS_TERM_EN && (DATA_TERM_VALUE == FIELD_OFF))
    else $error("data termination on with field zero");

  AST_LEVELING_PATTERN: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (WRITE_LEVEL && term_gate) |=> DQS_TERM_EN && !DQ_TERM_EN && !DATA_MASK_INV_TERM_EN)
    else $error("write leveling termination pattern wrong");

  AST_TURN_ON_POINT: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (lr.slot[0].act && (lr.slot[0].on_cnt == CNT_ONE) && (lr.slot[0].off_cnt > 6'h02))
    |-> ##2 (DQ_TERM_EN || !term_gate || WRITE_LEVEL))
    else $error("termination not on when turn-on latency expired");

  AST_TURN_OFF_POINT: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    ((win_r == 8'h01) && (lr.slot[0].off_cnt == CNT_ONE) && !CMD_CAS2)
    |=> ##1 (!DQ_TERM_EN || (|win_r)))
    else $error("termination still on after turn-off latency");

  AST_LOAD_LATENCY: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (CMD_CAS2 && lr.wr_pend && (lr.dfield != FIELD_OFF) && !lr.slot[0].act)
    |=> (lr.slot[0].off_cnt == $past(off_sel) - CNT_ONE) &&
        (lr.slot[0].on_cnt == $past(on_sel) - CNT_ONE))
    else $error("slot not loaded with the selected latencies");

  // nothing in flight and no leveling: all data pins stay high impedance
  AST_IDLE_HIGH_Z: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (!(|win_r) && !WRITE_LEVEL) |=> !DQ_TERM_EN && !DQS_TERM_EN && !DATA_MASK_INV_TERM_EN)
    else $error("data termination on with no write window open");

  AST_WINDOW_OPENS: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    ((|win_r) && term_gate && !WRITE_LEVEL)
    |=> DQ_TERM_EN && DQS_TERM_EN && DATA_MASK_INV_TERM_EN)
    else $error("open window did not terminate data, strobe and mask pins");

  AST_DATA_VALUE_GATED: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    term_gate |=> (DATA_TERM_VALUE == $past(lr.dfield)))
    else $error("data termination value differs from the field");

  // a write that finds every counter pair busy gets no window, so flag it
  AST_SLOT_OVERFLOW: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    (CMD_CAS2 && lr.wr_pend && (lr.dfield != FIELD_OFF) && (&slot_busy))
    |=> WRITE_SLOT_OVERFLOW)
    else $error("write with all counters busy not flagged");

  AST_NO_FALSE_OVERFLOW: assert property (
    @(posedge LINK_CK) disable iff (!link_rst_n)
    !(&slot_busy) |=> !WRITE_SLOT_OVERFLOW)
    else $error("overflow flagged with a free counter pair");

  // command side: arrival starts the wait, undefined code terminates nothing
  AST_BUSY_ON_ARRIVAL: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_valid |=> CA_UPDATE_BUSY)
    else $error("update wait not started on arrival");

  AST_CA_CODE_UNDEFINED: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (sr.cafield > CA_CODE_MAX) |=> !CA_TERM_EN && (CA_TERM_VALUE == FIELD_OFF))
    else $error("undefined command code terminated the bus");

endmodule : dram_on_die_termination_ctrl
`default_nettype wire

// *** dv/term_ctrl_model.sv ***
// memory controller model: link clock, write commands and mode writes
`timescale 1ns/10ps
`default_nettype none
module term_ctrl_model
(
  // link clock and command pulses toward the device
  output logic                        link_ck,
  output logic                        cmd_write1,
  output logic                        cmd_cas2,
  output logic                        cmd_mrw_term,
  output logic [term_pkg::CFG_W-1:0]  mrw_data
);
  import term_pkg::*;

  // link clock runs free, phase offset from the system clock
  initial
  begin
    link_ck = 1'b0;
    #7;
    forever #32 link_ck = ~link_ck;
  end

  // idle command lines at time zero
  initial
  begin
    cmd_write1   = 1'b0;
    cmd_cas2     = 1'b0;
    cmd_mrw_term = 1'b0;
    mrw_data     = 8'hA5;
  end

  // write-1 then second column command on the next edge
  task automatic write_burst();
    @(negedge link_ck);
    cmd_write1 = 1'b1;
    @(negedge link_ck);
    cmd_write1 = 1'b0;
    cmd_cas2   = 1'b1;
    @(negedge link_ck);
    cmd_cas2   = 1'b0;
  endtask : write_burst

  // mode write; data shows the inverse afterwards so stale data is never trusted
  task automatic mode_write(input logic [CFG_W-1:0] d);
    @(negedge link_ck);
    cmd_mrw_term = 1'b1;
    mrw_data     = d;
    @(negedge link_ck);
    cmd_mrw_term = 1'b0;
    mrw_data     = ~d;
  endtask : mode_write
endmodule : term_ctrl_model
`default_nettype wire

// *** dv/dram_on_die_termination_ctrl_tb.sv ***
// self-checking bench for the termination control block
`timescale 1ns/10ps
`default_nettype none
module dram_on_die_termination_ctrl_tb;
  import term_pkg::*;
  logic               CLK, RESETN, LINK_CK, CMD_WRITE1, CMD_CAS2, CMD_MRW_TERM;
  logic [CFG_W-1:0]   MRW_DATA;
  logic               POWER_DOWN, SELF_REFRESH, WRITE_LEVEL, WRITE_LATENCY_SET_B;
  logic               BURST_LEN_32, CA_TERM_BOND_PAD, CA_TERM_EN, CA_UPDATE_BUSY;
  logic [BAND_W-1:0]  FREQ_BAND;
  logic               DQ_TERM_EN, DQS_TERM_EN, DATA_MASK_INV_TERM_EN, WRITE_SLOT_OVERFLOW;
  logic [FIELD_W-1:0] DATA_TERM_VALUE, CA_TERM_VALUE;
  logic [3:0]         ca_exp;
  int                 miscompares, n_checks, cyc;
  // latencies per frequency band, independent of the design's tables
  int on_a[8]  = '{2, 2, 2, 4, 4, 6, 6, 8};
  int on_b[8]  = '{2, 2, 6, 12, 14, 18, 20, 24};
  int off_a[8] = '{14, 16, 18, 20, 22, 24, 26, 28};
  int off_b[8] = '{14, 18, 22, 28, 32, 36, 40, 44};

  term_ctrl_model ctl_u (.link_ck(LINK_CK), .cmd_write1(CMD_WRITE1), .cmd_cas2(CMD_CAS2),
    .cmd_mrw_term(CMD_MRW_TERM), .mrw_data(MRW_DATA));

  dram_on_die_termination_ctrl dut_u (.CLK(CLK), .RESETN(RESETN), .LINK_CK(LINK_CK),
    .CMD_WRITE1(CMD_WRITE1), .CMD_CAS2(CMD_CAS2), .CMD_MRW_TERM(CMD_MRW_TERM),
    .MRW_DATA(MRW_DATA), .POWER_DOWN(POWER_DOWN), .SELF_REFRESH(SELF_REFRESH),
    .WRITE_LEVEL(WRITE_LEVEL), .FREQ_BAND(FREQ_BAND),
    .WRITE_LATENCY_SET_B(WRITE_LATENCY_SET_B), .BURST_LEN_32(BURST_LEN_32),
    .DQ_TERM_EN(DQ_TERM_EN), .DQS_TERM_EN(DQS_TERM_EN),
    .DATA_MASK_INV_TERM_EN(DATA_MASK_INV_TERM_EN), .DATA_TERM_VALUE(DATA_TERM_VALUE),
    .WRITE_SLOT_OVERFLOW(WRITE_SLOT_OVERFLOW), .CA_TERM_BOND_PAD(CA_TERM_BOND_PAD),
    .CA_TERM_EN(CA_TERM_EN), .CA_TERM_VALUE(CA_TERM_VALUE), .CA_UPDATE_BUSY(CA_UPDATE_BUSY));

  // system clock, 25 ns
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // counts, verdict, end of run
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // follows the data enables edge by edge after a second column command
  task automatic watch(input int on, input int off, input int lag, input logic en,
                       input logic [2:0] val);
    logic       w;
    logic [7:0] got;
    for (int j = 1; j <= off + 3; j++)
    begin
      @(negedge LINK_CK);
      w = en && ((j >= on && j < off) || (lag > 0 && j + lag >= on && j + lag < off));
      got = {1'b0, WRITE_SLOT_OVERFLOW, DQ_TERM_EN, DQS_TERM_EN, DATA_MASK_INV_TERM_EN,
             DATA_TERM_VALUE};
      check(got, {2'h0, w, w, w, val});
    end
  endtask : watch

  // command field mode write, old value held through the update wait
  task automatic ca_write(input logic [2:0] code);
    int   k;
    logic e;
    e = CA_TERM_BOND_PAD && code != 3'h0 && code != 3'h7;
    ctl_u.mode_write({1'b0, code, 4'h2});
    for (k = 0; k < 40 && CA_UPDATE_BUSY !== 1'b1; k++)
      @(negedge CLK);
    check(8'(k < 40), 8'h01);
    check({4'h0, CA_TERM_EN, CA_TERM_VALUE}, {4'h0, ca_exp});
    repeat (2) @(negedge CLK);
    ca_exp = {e, e ? code : 3'h0};
    check({3'h0, CA_UPDATE_BUSY, CA_TERM_EN, CA_TERM_VALUE}, {4'h0, ca_exp});
  endtask : ca_write

  // cycle ceiling against a hang
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    RESETN = 1'b0;
    POWER_DOWN = 1'b0;
    SELF_REFRESH = 1'b0;
    WRITE_LEVEL = 1'b0;
    FREQ_BAND = 3'h0;
    WRITE_LATENCY_SET_B = 1'b0;
    BURST_LEN_32 = 1'b0;
    CA_TERM_BOND_PAD = 1'b1;
    ca_exp = 4'h0;
    repeat (3) @(negedge CLK);
    check({3'h0, DQ_TERM_EN, DQS_TERM_EN, DATA_MASK_INV_TERM_EN, WRITE_SLOT_OVERFLOW,
           CA_UPDATE_BUSY}, 8'h00);
    check({4'h0, CA_TERM_EN, CA_TERM_VALUE}, 8'h00);
    repeat (2) @(negedge CLK);
    RESETN = 1'b1;
    repeat (4) @(negedge LINK_CK);
    $display("test reset done");
    // every band in both latency sets, short bursts
    ctl_u.mode_write(8'h02);
    for (int s = 0; s < 2; s++)
      for (int b = 0; b < 8; b++)
      begin
        FREQ_BAND = 3'(b);
        WRITE_LATENCY_SET_B = s[0];
        ctl_u.write_burst();
        watch(s ? on_b[b] : on_a[b], s ? off_b[b] : off_a[b], 0, 1'b1, 3'h2);
      end
    BURST_LEN_32 = 1'b1;
    ctl_u.write_burst();
    watch(on_b[7], off_b[7] + 8, 0, 1'b1, 3'h2);
    // nine writes inside the longest window: the ninth finds no free counter
    for (int w = 0; w < 9; w++)
    begin
      ctl_u.write_burst();
      check({7'h0, WRITE_SLOT_OVERFLOW}, {7'h0, w == 8});
    end
    repeat (60) @(negedge LINK_CK);
    check({7'h0, DQ_TERM_EN}, 8'h00);
    BURST_LEN_32 = 1'b0;
    $display("test latency table done");
    // back-to-back writes keep the window closed-free
    FREQ_BAND = 3'h0;
    WRITE_LATENCY_SET_B = 1'b0;
    ctl_u.write_burst();
    ctl_u.write_burst();
    watch(2, 14, 3, 1'b1, 3'h2);
    // field selects the value; zero disables
    ctl_u.mode_write(8'h05);
    ctl_u.write_burst();
    watch(2, 14, 0, 1'b1, 3'h5);
    ctl_u.mode_write(8'h00);
    ctl_u.write_burst();
    watch(2, 14, 0, 1'b0, 3'h0);
    $display("test data windows done");
    // power-down and self-refresh suppress data termination
    ctl_u.mode_write(8'h02);
    for (int p = 0; p < 2; p++)
    begin
      POWER_DOWN = (p == 0);
      SELF_REFRESH = (p == 1);
      ctl_u.write_burst();
      watch(2, 14, 0, 1'b0, 3'h0);
    end
    POWER_DOWN = 1'b0;
    SELF_REFRESH = 1'b0;
    // write leveling: strobe only, and nothing with the field at zero
    WRITE_LEVEL = 1'b1;
    repeat (2) @(negedge LINK_CK);
    check({5'h0, DQ_TERM_EN, DQS_TERM_EN, DATA_MASK_INV_TERM_EN}, 8'h02);
    ctl_u.mode_write(8'h00);
    repeat (2) @(negedge LINK_CK);
    check({5'h0, DQ_TERM_EN, DQS_TERM_EN, DATA_MASK_INV_TERM_EN}, 8'h00);
    WRITE_LEVEL = 1'b0;
    $display("test power states done");
    // command field codes with the pad high; let earlier crossings settle first
    repeat (20) @(negedge CLK);
    for (int c = 1; c < 8; c++)
      ca_write(3'(c));
    ca_write(3'h3);
    POWER_DOWN = 1'b1;
    repeat (4) @(negedge CLK);
    check({4'h0, CA_TERM_EN, CA_TERM_VALUE}, 8'h0B);
    POWER_DOWN = 1'b0;
    CA_TERM_BOND_PAD = 1'b0;
    repeat (5) @(negedge CLK);
    check({4'h0, CA_TERM_EN, CA_TERM_VALUE}, 8'h00);
    // pad low masks the programmed code, so the level before the next write is off
    ca_exp = 4'h0;
    ca_write(3'h5);
    CA_TERM_BOND_PAD = 1'b1;
    repeat (5) @(negedge CLK);
    check({4'h0, CA_TERM_EN, CA_TERM_VALUE}, 8'h0D);
    $display("test command termination done");
    close_out();
  end
endmodule : dram_on_die_termination_ctrl_tb
`default_nettype wire
